/* bstp_params.svh */
// constants of the boundary-scan test port: codes, patterns and defaults
`ifndef BSTP_PARAMS_SVH
`define BSTP_PARAMS_SVH

// ----------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------
`define BSTP_IR_LEN        10
`define BSTP_IR_CAPTURE    10'h2AA
`define BSTP_OP_EXTEST     10'h000
`define BSTP_OP_SAMPLE     10'h005
`define BSTP_OP_IDCODE     10'h006
`define BSTP_OP_USERCODE   10'h007
`define BSTP_OP_CLAMP      10'h00A
`define BSTP_OP_HIGHZ      10'h00B
`define BSTP_OP_CONFIG_IO  10'h00D
`define BSTP_OP_BYPASS     10'h3FF

// ----------------------------------------------------------------
// data registers
// ----------------------------------------------------------------
`define BSTP_ID_LEN        32
`define BSTP_IDCODE_DFLT   32'h0F0F_0001 // arbitrary identification value
`define BSTP_USERCODE_DFLT 32'hFFFF_FFFF
`define BSTP_CELLS_PER_PIN 3
`define BSTP_CELL_IN       0
`define BSTP_CELL_OE       1
`define BSTP_CELL_OUT      2

// ----------------------------------------------------------------
// tester side
// ----------------------------------------------------------------
// tms bits, first one in bit 0: five ones to reset, then 0,1,1,0,0
`define BSTP_TMS_TO_SHIFT_IR 10'h0DF
`define BSTP_TMS_TO_SHIFT_IR_LEN 10
`define BSTP_TCK_HALF_DFLT 4

`endif

/* bstp_pkg.sv */
// types shared by both ends of the boundary-scan test port
package bstp_pkg;

   typedef enum logic [3:0] {
      S_TLR, S_RTI, S_SELDR, S_CAPDR, S_SHDR, S_EX1DR, S_PAUSEDR, S_EX2DR,
      S_UPDDR, S_SELIR, S_CAPIR, S_SHIR, S_EX1IR, S_PAUSEIR, S_EX2IR, S_UPDIR
   } bstp_tap_t;

   typedef enum logic [1:0] {
      PATH_BYPASS, PATH_ID, PATH_USER, PATH_BSR
   } bstp_path_t;

   typedef enum logic [1:0] {
      MODE_NORMAL, MODE_EXTEST, MODE_HIGHZ
   } bstp_mode_t;

   typedef enum logic [1:0] {
      T_IDLE, T_LOW, T_HIGH
   } bstp_tst_t;

endpackage : bstp_pkg

/* bstp_link_if.sv */
// serial test link between the tester and the device
`timescale 1ns/1ps
interface bstp_link_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe;

   modport dev (
      input  tck,
      input  tms,
      input  tdi,
      output tdo,
      output tdo_oe
   );

   modport tst (
      output tck,
      output tms,
      output tdi,
      input  tdo,
      input  tdo_oe
   );
endinterface : bstp_link_if

/* bstp_tester.sv */
// tester end: makes the test clock and shifts tms/tdi vectors, collects tdo
`timescale 1ns/1ps
`include "bstp_params.svh"
module bstp_tester
   import bstp_pkg::*;
#(
   parameter int NB   = 32,
   parameter int HALF = `BSTP_TCK_HALF_DFLT
) (
   input  wire logic                    REF_CLK,
   input  wire logic                    RSTN,
   bstp_link_if.tst                     LINK,
   input  wire logic                    START,
   input  wire logic                    GO_SHIFT_IR,
   input  wire logic [$clog2(NB+1)-1:0] NBITS,
   input  wire logic [NB-1:0]           TMS_VEC,
   input  wire logic [NB-1:0]           TDI_VEC,
   input  wire logic                    IS_EXTEST,
   input  wire logic                    IS_PRELOAD,
   input  wire logic                    RECONFIG_BUSY,
   input  wire logic                    PRECONFIG_TEST,
   output logic                         BUSY,
   output logic                         DONE,
   output logic                         REFUSED,
   output logic [NB-1:0]                TDO_VEC,
   output logic                         CONFIG_RESTART_N
);
   localparam int CW = $clog2(NB+1);
   localparam int DW = $clog2(HALF+1);

   if (NB < `BSTP_TMS_TO_SHIFT_IR_LEN || HALF < 3) begin : g_bad_params
      $error("bstp_tester: NB must be >= 10 and HALF >= 3");
   end

   bstp_tst_t       st_q, st_d;
   logic [DW-1:0]   div_q, div_d;
   logic [CW-1:0]   cnt_q, cnt_d, len_q, len_d;
   logic [NB-1:0]   tms_sh_q, tms_sh_d, tdi_sh_q, tdi_sh_d, tdo_v_q, tdo_v_d;
   logic            tck_q, tck_d, tms_q, tms_d, tdi_q, tdi_d;
   logic            done_q, done_d, ref_q, ref_d, pre_q, pre_d, rst_n_q, rst_n_d;
   logic            tdo_s1_q, tdo_s2_q;
   logic            busy_q, busy_d;
   logic            refuse;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      st_d     = st_q;
      div_d    = div_q;
      cnt_d    = cnt_q;
      len_d    = len_q;
      tms_sh_d = tms_sh_q;
      tdi_sh_d = tdi_sh_q;
      tdo_v_d  = tdo_v_q;
      tck_d    = tck_q;
      tms_d    = tms_q;
      tdi_d    = tdi_q;
      done_d   = 1'b0;
      ref_d    = 1'b0;
      pre_d    = pre_q;
      // an extest before any preload, or while the device reconfigures, is refused
      refuse   = IS_EXTEST && (RECONFIG_BUSY || !pre_q);
      rst_n_d  = !PRECONFIG_TEST;
      case (st_q)
         T_IDLE: begin
            if (GO_SHIFT_IR) begin
               tms_sh_d = NB'(`BSTP_TMS_TO_SHIFT_IR);
               tdi_sh_d = '0;
               len_d    = CW'(`BSTP_TMS_TO_SHIFT_IR_LEN);
               cnt_d    = '0;
               div_d    = '0;
               st_d     = T_LOW;
            end else if (START && refuse) begin
               ref_d    = 1'b1;
            end else if (START && NBITS != '0) begin
               tms_sh_d = TMS_VEC;
               tdi_sh_d = TDI_VEC;
               len_d    = NBITS;
               cnt_d    = '0;
               div_d    = '0;
               pre_d    = pre_q || IS_PRELOAD;
               st_d     = T_LOW;
            end
         end
         T_LOW: begin
            tms_d = tms_sh_q[0];
            tdi_d = tdi_sh_q[0];
            div_d = div_q + DW'(1);
            if (div_q == DW'(HALF - 1)) begin
               div_d = '0;
               tck_d = 1'b1;
               st_d  = T_HIGH;
            end
         end
         T_HIGH: begin
            div_d = div_q + DW'(1);
            if (div_q == DW'(HALF - 1)) begin
               div_d          = '0;
               tck_d          = 1'b0;
               tdo_v_d[cnt_q] = tdo_s2_q;
               tms_sh_d       = tms_sh_q >> 1;
               tdi_sh_d       = tdi_sh_q >> 1;
               cnt_d          = cnt_q + CW'(1);
               if (cnt_q == len_q - CW'(1)) begin
                  done_d = 1'b1;
                  st_d   = T_IDLE;
               end else begin
                  st_d   = T_LOW;
               end
            end
         end
         default: st_d = T_IDLE;
      endcase
      busy_d = (st_d != T_IDLE);
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_q     <= T_IDLE;
         div_q    <= '0;
         cnt_q    <= '0;
         len_q    <= '0;
         tms_sh_q <= '0;
         tdi_sh_q <= '0;
         tdo_v_q  <= '0;
         tck_q    <= 1'b0;
         tms_q    <= 1'b1;
         tdi_q    <= 1'b1;
         done_q   <= 1'b0;
         ref_q    <= 1'b0;
         pre_q    <= 1'b0;
         rst_n_q  <= 1'b1;
         busy_q   <= 1'b0;
      end else begin
         st_q     <= st_d;
         div_q    <= div_d;
         cnt_q    <= cnt_d;
         len_q    <= len_d;
         tms_sh_q <= tms_sh_d;
         tdi_sh_q <= tdi_sh_d;
         tdo_v_q  <= tdo_v_d;
         tck_q    <= tck_d;
         tms_q    <= tms_d;
         tdi_q    <= tdi_d;
         done_q   <= done_d;
         ref_q    <= ref_d;
         pre_q    <= pre_d;
         rst_n_q  <= rst_n_d;
         busy_q   <= busy_d;
      end
   end

   // tdo moves on the device's test clock, so it is synchronised first
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         tdo_s1_q <= 1'b0;
         tdo_s2_q <= 1'b0;
      end else begin
         tdo_s1_q <= LINK.tdo;
         tdo_s2_q <= tdo_s1_q;
      end
   end

   assign LINK.tck         = tck_q;
   assign LINK.tms         = tms_q;
   assign LINK.tdi         = tdi_q;
   assign BUSY             = busy_q;
   assign DONE             = done_q;
   assign REFUSED          = ref_q;
   assign TDO_VEC          = tdo_v_q;
   assign CONFIG_RESTART_N = rst_n_q;

endmodule : bstp_tester

/* bstp_device.sv */
// device end: tap controller, scan registers and pin multiplexer
`timescale 1ns/1ps
`include "bstp_params.svh"
// Summary of operation
// - shift-ir first bits show 0101010101, lsb first
// - tester reaches shift-ir from reset with 01100
// - extest drives output cell when enable cell 0
// - tester preloads update cells before first extest
// - no extest while reconfiguration is in progress
// - configuration-interrupt instruction aborts running configuration
// - tester holds restart pin low before configuration
// - configured differential pins act as internal cells
// - port always enabled, dedicated pins, no disable
// - decode all seven standard instructions with paths
// - all-ones selects one-bit bypass, tdo on fall
// - idcode loads 32-bit identification register for shifting
module bstp_device
   import bstp_pkg::*;
#(
   parameter int                 NPINS     = 8,
   parameter logic [31:0]        IDCODE    = `BSTP_IDCODE_DFLT,
   parameter logic [31:0]        USERCODE  = `BSTP_USERCODE_DFLT,
   parameter logic [NPINS-1:0]   DIFF_MASK = '0
) (
   input  wire logic             REF_CLK,
   input  wire logic             RSTN,
   bstp_link_if.dev              LINK,
   input  wire logic [NPINS-1:0] PIN_IN,
   input  wire logic [NPINS-1:0] CORE_OUT,
   input  wire logic [NPINS-1:0] CORE_OE,
   input  wire logic             CONFIG_BUSY,
   input  wire logic             CONFIGURED,
   output logic      [NPINS-1:0] PIN_OUT,
   output logic      [NPINS-1:0] PIN_OE,
   output logic                  CONFIG_ABORT
);
   // the identification value above is arbitrary
   localparam int IRL = `BSTP_IR_LEN;
   localparam int BL  = NPINS * `BSTP_CELLS_PER_PIN;

   if (NPINS < 1) begin : g_bad_params
      $error("bstp_device: NPINS must be at least 1");
   end

   function automatic bstp_path_t path_of(input logic [IRL-1:0] ir);
      case (ir)
         `BSTP_OP_IDCODE:   path_of = PATH_ID;
         `BSTP_OP_USERCODE: path_of = PATH_USER;
         `BSTP_OP_EXTEST,
         `BSTP_OP_SAMPLE:   path_of = PATH_BSR;
         default:           path_of = PATH_BYPASS;
      endcase
   endfunction : path_of

   function automatic bstp_mode_t mode_of(input logic [IRL-1:0] ir);
      case (ir)
         `BSTP_OP_EXTEST,
         `BSTP_OP_CLAMP:    mode_of = MODE_EXTEST;
         `BSTP_OP_HIGHZ:    mode_of = MODE_HIGHZ;
         default:           mode_of = MODE_NORMAL;
      endcase
   endfunction : mode_of

   // ----------------------------------------------------------------
   // test-clock domain: synchronisers
   // ----------------------------------------------------------------
   // no enable input exists: the port runs from power-up whatever the core does
   logic [NPINS-1:0] pin_s1_q, pin_s2_q, cout_s1_q, cout_s2_q, coe_s1_q, coe_s2_q;
   logic             busy_s1_q, busy_s2_q, cfg_s1_q, cfg_s2_q;

   always_ff @(posedge LINK.tck or negedge RSTN) begin
      if (!RSTN) begin
         pin_s1_q  <= '0;
         pin_s2_q  <= '0;
         cout_s1_q <= '0;
         cout_s2_q <= '0;
         coe_s1_q  <= '0;
         coe_s2_q  <= '0;
         busy_s1_q <= 1'b0;
         busy_s2_q <= 1'b0;
         cfg_s1_q  <= 1'b0;
         cfg_s2_q  <= 1'b0;
      end else begin
         pin_s1_q  <= PIN_IN;
         pin_s2_q  <= pin_s1_q;
         cout_s1_q <= CORE_OUT;
         cout_s2_q <= cout_s1_q;
         coe_s1_q  <= CORE_OE;
         coe_s2_q  <= coe_s1_q;
         busy_s1_q <= CONFIG_BUSY;
         busy_s2_q <= busy_s1_q;
         cfg_s1_q  <= CONFIGURED;
         cfg_s2_q  <= cfg_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // test-clock domain: tap controller and scan registers
   // ----------------------------------------------------------------
   bstp_tap_t        st_q, st_d;
   bstp_mode_t       mode_q, mode_d;
   logic [IRL-1:0]   ir_q, ir_d, irs_q, irs_d;
   logic [31:0]      ids_q, ids_d;
   logic [BL-1:0]    bsr_q, bsr_d;
   logic [NPINS-1:0] uoe_q, uoe_d, uout_q, uout_d;
   logic             byp_q, byp_d, utgl_q, utgl_d, atgl_q, atgl_d;
   logic             tms, tdi;
   bstp_path_t       path;

   assign tms  = LINK.tms;
   assign tdi  = LINK.tdi;
   assign path = path_of(ir_q);

   always_comb begin
      case (st_q)
         S_TLR:     st_d = tms ? S_TLR     : S_RTI;
         S_RTI:     st_d = tms ? S_SELDR   : S_RTI;
         S_SELDR:   st_d = tms ? S_SELIR   : S_CAPDR;
         S_CAPDR:   st_d = tms ? S_EX1DR   : S_SHDR;
         S_SHDR:    st_d = tms ? S_EX1DR   : S_SHDR;
         S_EX1DR:   st_d = tms ? S_UPDDR   : S_PAUSEDR;
         S_PAUSEDR: st_d = tms ? S_EX2DR   : S_PAUSEDR;
         S_EX2DR:   st_d = tms ? S_UPDDR   : S_SHDR;
         S_UPDDR:   st_d = tms ? S_SELDR   : S_RTI;
         S_SELIR:   st_d = tms ? S_TLR     : S_CAPIR;
         S_CAPIR:   st_d = tms ? S_EX1IR   : S_SHIR;
         S_SHIR:    st_d = tms ? S_EX1IR   : S_SHIR;
         S_EX1IR:   st_d = tms ? S_UPDIR   : S_PAUSEIR;
         S_PAUSEIR: st_d = tms ? S_EX2IR   : S_PAUSEIR;
         S_EX2IR:   st_d = tms ? S_UPDIR   : S_SHIR;
         S_UPDIR:   st_d = tms ? S_SELDR   : S_RTI;
         default:   st_d = S_TLR;
      endcase
   end

   always_comb begin
      ir_d   = ir_q;
      irs_d  = irs_q;
      ids_d  = ids_q;
      bsr_d  = bsr_q;
      byp_d  = byp_q;
      uoe_d  = uoe_q;
      uout_d = uout_q;
      mode_d = mode_q;
      utgl_d = utgl_q;
      atgl_d = atgl_q;
      case (st_q)
         S_TLR: begin
            ir_d   = `BSTP_OP_IDCODE;
            mode_d = MODE_NORMAL;
            // the pin side must also fall back to normal mode, so toggle once
            if (mode_q != MODE_NORMAL) begin
               utgl_d = !utgl_q;
            end
         end
         S_CAPIR: irs_d = `BSTP_IR_CAPTURE;
         S_SHIR:  irs_d = {tdi, irs_q[IRL-1:1]};
         S_UPDIR: begin
            ir_d = irs_q;
            // pin-driving instructions are turned away while configuration runs
            if (busy_s2_q && mode_of(irs_q) != MODE_NORMAL) begin
               ir_d = `BSTP_OP_BYPASS;
            end
            if (irs_q == `BSTP_OP_CONFIG_IO) begin
               atgl_d = !atgl_q;
            end
            mode_d = mode_of(ir_d);
            utgl_d = !utgl_q;
         end
         S_CAPDR: begin
            case (path)
               PATH_ID:   ids_d = IDCODE;
               PATH_USER: ids_d = cfg_s2_q ? USERCODE : `BSTP_USERCODE_DFLT;
               PATH_BSR: begin
                  for (int i = 0; i < NPINS; i++) begin
                     // configured differential pins capture core data, not the pad
                     bsr_d[3*i+`BSTP_CELL_IN]  = (cfg_s2_q && DIFF_MASK[i]) ?
                                                 cout_s2_q[i] : pin_s2_q[i];
                     bsr_d[3*i+`BSTP_CELL_OE]  = !coe_s2_q[i];
                     bsr_d[3*i+`BSTP_CELL_OUT] = cout_s2_q[i];
                  end
               end
               default:   byp_d = 1'b0;
            endcase
         end
         S_SHDR: begin
            case (path)
               PATH_ID,
               PATH_USER: ids_d = {tdi, ids_q[31:1]};
               PATH_BSR:  bsr_d = {tdi, bsr_q[BL-1:1]};
               default:   byp_d = tdi;
            endcase
         end
         S_UPDDR: begin
            if (path == PATH_BSR) begin
               for (int i = 0; i < NPINS; i++) begin
                  uoe_d[i]  = bsr_q[3*i+`BSTP_CELL_OE];
                  uout_d[i] = bsr_q[3*i+`BSTP_CELL_OUT];
               end
               utgl_d = !utgl_q;
            end
         end
         default: ;
      endcase
   end

   always_ff @(posedge LINK.tck or negedge RSTN) begin
      if (!RSTN) begin
         st_q   <= S_TLR;
         mode_q <= MODE_NORMAL;
         ir_q   <= `BSTP_OP_IDCODE;
         irs_q  <= '0;
         ids_q  <= '0;
         bsr_q  <= '0;
         byp_q  <= 1'b0;
         uoe_q  <= '1;
         uout_q <= '0;
         utgl_q <= 1'b0;
         atgl_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         mode_q <= mode_d;
         ir_q   <= ir_d;
         irs_q  <= irs_d;
         ids_q  <= ids_d;
         bsr_q  <= bsr_d;
         byp_q  <= byp_d;
         uoe_q  <= uoe_d;
         uout_q <= uout_d;
         utgl_q <= utgl_d;
         atgl_q <= atgl_d;
      end
   end

   // ----------------------------------------------------------------
   // test-clock domain: tdo, moved on the falling edge
   // ----------------------------------------------------------------
   logic tdo_q, tdo_d, tdoe_q, tdoe_d;

   always_comb begin
      tdo_d  = tdo_q;
      tdoe_d = 1'b0;
      if (st_q == S_SHIR) begin
         tdo_d  = irs_q[0];
         tdoe_d = 1'b1;
      end else if (st_q == S_SHDR) begin
         tdoe_d = 1'b1;
         case (path)
            PATH_ID,
            PATH_USER: tdo_d = ids_q[0];
            PATH_BSR:  tdo_d = bsr_q[0];
            default:   tdo_d = byp_q;
         endcase
      end
   end

   always_ff @(negedge LINK.tck or negedge RSTN) begin
      if (!RSTN) begin
         tdo_q  <= 1'b0;
         tdoe_q <= 1'b0;
      end else begin
         tdo_q  <= tdo_d;
         tdoe_q <= tdoe_d;
      end
   end

   assign LINK.tdo    = tdo_q;
   assign LINK.tdo_oe = tdoe_q;

   // ----------------------------------------------------------------
   // reference domain: pin multiplexer and abort pulse
   // ----------------------------------------------------------------
   // mode and update cells only change at an update state or in test-logic-reset and then sit
   // still for many test clocks, so a synchronised toggle qualifies them
   logic [2:0]       us_q, as_q;
   bstp_mode_t       rmode_q, rmode_d;
   logic [NPINS-1:0] roe_q, roe_d, rout_q, rout_d, pout_q, pout_d, poe_q, poe_d;
   logic             abort_q, abort_d;

   always_comb begin
      rmode_d = rmode_q;
      roe_d   = roe_q;
      rout_d  = rout_q;
      if (us_q[1] != us_q[2]) begin
         rmode_d = mode_q;
         roe_d   = uoe_q;
         rout_d  = uout_q;
      end
      abort_d = (as_q[1] != as_q[2]);
      for (int i = 0; i < NPINS; i++) begin
         pout_d[i] = CORE_OUT[i];
         poe_d[i]  = CORE_OE[i];
         if (!(CONFIGURED && DIFF_MASK[i])) begin
            if (rmode_q == MODE_EXTEST) begin
               poe_d[i]  = !roe_q[i];
               pout_d[i] = rout_q[i];
            end else if (rmode_q == MODE_HIGHZ) begin
               poe_d[i]  = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         us_q    <= '0;
         as_q    <= '0;
         rmode_q <= MODE_NORMAL;
         roe_q   <= '1;
         rout_q  <= '0;
         pout_q  <= '0;
         poe_q   <= '0;
         abort_q <= 1'b0;
      end else begin
         us_q    <= {us_q[1:0], utgl_q};
         as_q    <= {as_q[1:0], atgl_q};
         rmode_q <= rmode_d;
         roe_q   <= roe_d;
         rout_q  <= rout_d;
         pout_q  <= pout_d;
         poe_q   <= poe_d;
         abort_q <= abort_d;
      end
   end

   assign PIN_OUT      = pout_q;
   assign PIN_OE       = poe_q;
   assign CONFIG_ABORT = abort_q;

endmodule : bstp_device

/* bstp_chk.sv */
// assertions watching the test link between tester and device
`timescale 1ns/1ps
`include "bstp_params.svh"
module bstp_chk
   import bstp_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe
);
   // ----------------------------------------------------------------
   // reference tap walk; next states packed four bits per state
   // ----------------------------------------------------------------
   localparam logic [63:0] NXT0 = 64'h1BDDBBA146644311;
   localparam logic [63:0] NXT1 = 64'h2FEFCC0287855920;
   localparam logic [9:0]  CAP  = `BSTP_IR_CAPTURE;
   bstp_tap_t  st_q, st_d;
   logic [3:0] cnt_q, cnt_d;

   always_comb begin
      st_d  = bstp_tap_t'(tms ? NXT1[{st_q, 2'b00} +: 4] : NXT0[{st_q, 2'b00} +: 4]);
      cnt_d = (st_q == S_CAPIR) ? 4'h0 : cnt_q + {3'h0, (st_q == S_SHIR) && (cnt_q != 4'hF)};
   end

   always_ff @(posedge tck or negedge RSTN) begin
      if (!RSTN) begin
         st_q  <= S_TLR;
         cnt_q <= 4'h0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // ----------------------------------------------------------------
   // link checks; tck is oversampled on REF_CLK
   // ----------------------------------------------------------------
   chk_tdo_on_fall: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      $changed(tdo) |-> $fell(tck)) else $error("tdo moved off a falling tck");
   chk_oe_on_fall: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      $changed(tdo_oe) |-> $fell(tck)) else $error("tdo_oe moved off a falling tck");
   chk_oe_shift_only: assert property (@(posedge tck) disable iff (!RSTN)
      tdo_oe == (st_q == S_SHIR || st_q == S_SHDR)) else $error("tdo_oe outside shift");
   chk_ir_capture_bits: assert property (@(posedge tck) disable iff (!RSTN)
      (st_q == S_SHIR && cnt_q < 4'hA) |-> tdo == CAP[cnt_q]) else $error("bad ir pattern");
   chk_link_stable: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      $past(tck) && tck |-> $stable(tms) && $stable(tdi)) else $error("tms/tdi moved high");
   chk_tck_high_half: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      $rose(tck) |-> tck [*4] ##1 !tck) else $error("tck high half wrong");
   chk_tck_low_half: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      $fell(tck) |-> !tck [*4]) else $error("tck low half too short");
   chk_oe_min_span: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      $rose(tdo_oe) |-> tdo_oe [*8]) else $error("tdo_oe shorter than one tck");

   cov_shift_ir: cover property (@(posedge tck) disable iff (!RSTN) st_q == S_SHIR);
   cov_update_dr: cover property (@(posedge tck) disable iff (!RSTN) st_q == S_UPDDR);
   cov_tdo_high: cover property (@(posedge REF_CLK) disable iff (!RSTN) tdo_oe && tdo);
endmodule : bstp_chk

/* tb_boundary_scan_test_port.sv */
// self-checking bench: tester and device joined over the test link
`timescale 1ns/1ps
`include "bstp_params.svh"
module tb_boundary_scan_test_port;
   localparam int NB = 40;
   logic          ref_clk = 1'b0, rstn = 1'b1, start = 1'b0, go_ir = 1'b0;
   logic          is_ext = 1'b0, is_pre = 1'b0, rcfg = 1'b0, pre_t = 1'b0;
   logic          cfg_busy = 1'b0, cfgd = 1'b0, busy, done, refused, restart_n, abort;
   logic [5:0]    nbits = 6'h00;
   logic [NB-1:0] tms_v = 40'h0, tdi_v = 40'h0, tdo_vec, tv = 40'h0;
   logic [3:0]    pin_in = 4'hA, core_out = 4'hB, core_oe = 4'h5, pin_out, pin_oe;
   int            bad_count = 0, total_checks = 0, aborts = 0;

   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (abort === 1'b1) aborts <= aborts + 1;

   bstp_link_if link ();
   bstp_tester #(.NB(NB), .HALF(4)) u_bstp_tester (.REF_CLK(ref_clk), .RSTN(rstn),
      .LINK(link.tst), .START(start), .GO_SHIFT_IR(go_ir), .NBITS(nbits), .TMS_VEC(tms_v),
      .TDI_VEC(tdi_v), .IS_EXTEST(is_ext), .IS_PRELOAD(is_pre), .RECONFIG_BUSY(rcfg),
      .PRECONFIG_TEST(pre_t), .BUSY(busy), .DONE(done), .REFUSED(refused),
      .TDO_VEC(tdo_vec), .CONFIG_RESTART_N(restart_n));
   bstp_device #(.NPINS(4), .DIFF_MASK(4'h8)) u_bstp_device (.REF_CLK(ref_clk),
      .RSTN(rstn), .LINK(link.dev), .PIN_IN(pin_in), .CORE_OUT(core_out),
      .CORE_OE(core_oe), .CONFIG_BUSY(cfg_busy), .CONFIGURED(cfgd), .PIN_OUT(pin_out),
      .PIN_OE(pin_oe), .CONFIG_ABORT(abort));
   bstp_chk u_bstp_chk (.REF_CLK(ref_clk), .RSTN(rstn), .tck(link.tck), .tms(link.tms),
      .tdi(link.tdi), .tdo(link.tdo), .tdo_oe(link.tdo_oe));

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [NB-1:0] seen, input logic [NB-1:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk

   // n of 0 walks the tap from reset into shift-ir
   task automatic xfer(input int n, input logic [NB-1:0] m, input logic [NB-1:0] d,
                       input logic ext, input logic pre, output logic refd);
      int i;
      refd = 1'b0;
      @(posedge ref_clk);
      start <= (n != 0);
      go_ir <= (n == 0);
      nbits <= 6'(n);
      tms_v <= m;
      tdi_v <= d;
      is_ext <= ext;
      is_pre <= pre;
      @(posedge ref_clk);
      start <= 1'b0;
      go_ir <= 1'b0;
      for (i = 0; i < 2000; i++) begin
         #1;
         if (refused === 1'b1) refd = 1'b1;
         if (done === 1'b1 || refd) break;
         @(posedge ref_clk);
      end
      tv = tdo_vec;
      if (i == 2000) begin
         bad_count++;
         $display("mismatch at %0t: transfer hung", $time);
         report_and_stop();
      end
      chk(NB'(busy), 40'h0);
   endtask : xfer

   task automatic load_ir(input logic [9:0] op, input logic ext, input logic pre,
                          output logic refd);
      xfer(0, 40'h0, 40'h0, 1'b0, 1'b0, refd);
      xfer(12, 40'h600, NB'(op), ext, pre, refd);
      if (!refd) chk(NB'(tv[9:0]), NB'(`BSTP_IR_CAPTURE));
   endtask : load_ir

   // data bit j rides tck clock 3+j, after the select/capture/shift entry
   task automatic dr(input int n, input logic [NB-1:0] d, output logic [NB-1:0] q);
      logic r;
      xfer(n + 5, 40'h1 | (40'h3 << (n + 2)), d << 3, 1'b0, 1'b0, r);
      q = (tv >> 3) & ((40'h1 << n) - 40'h1);
   endtask : dr

   task automatic idle(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask : idle

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      logic          r;
      logic [NB-1:0] q;
      // a real falling edge, so the test-clock flops reset before tck ever rises
      rstn <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      load_ir(`BSTP_OP_IDCODE, 1'b0, 1'b0, r);
      dr(32, 40'h0, q);
      chk(q, NB'(`BSTP_IDCODE_DFLT));
      load_ir(`BSTP_OP_BYPASS, 1'b0, 1'b0, r);
      dr(8, 40'h5B, q);
      chk(q, 40'hB6);
      load_ir(`BSTP_OP_USERCODE, 1'b0, 1'b0, r);
      dr(32, 40'h0, q);
      chk(q, NB'(`BSTP_USERCODE_DFLT));
      $display("test id paths done");
      load_ir(`BSTP_OP_EXTEST, 1'b1, 1'b0, r);
      chk(NB'(r), 40'h1);
      load_ir(`BSTP_OP_SAMPLE, 1'b0, 1'b1, r);
      dr(12, 40'h120, q);
      chk(q & 40'h249, 40'h208);
      @(posedge ref_clk) rcfg <= 1'b1;
      load_ir(`BSTP_OP_EXTEST, 1'b1, 1'b0, r);
      chk(NB'(r), 40'h1);
      @(posedge ref_clk) rcfg <= 1'b0;
      load_ir(`BSTP_OP_EXTEST, 1'b1, 1'b0, r);
      idle(8);
      chk(NB'({pin_oe, pin_out}), 40'hF6);
      @(posedge ref_clk) cfgd <= 1'b1;
      idle(8);
      chk(NB'({pin_oe, pin_out}), 40'h7E);
      $display("test preload and extest done");
      load_ir(`BSTP_OP_HIGHZ, 1'b0, 1'b0, r);
      idle(8);
      chk(NB'(pin_oe), 40'h0);
      load_ir(`BSTP_OP_CLAMP, 1'b0, 1'b0, r);
      idle(8);
      chk(NB'(pin_oe), 40'h7);
      dr(4, 40'h5, q);
      chk(q, 40'hA);
      @(posedge ref_clk) cfg_busy <= 1'b1;
      load_ir(`BSTP_OP_EXTEST, 1'b1, 1'b0, r);
      idle(8);
      chk(NB'({pin_oe, pin_out}), 40'h5B);
      load_ir(`BSTP_OP_CONFIG_IO, 1'b0, 1'b0, r);
      idle(8);
      chk(NB'(aborts), 40'h1);
      $display("test modes and abort done");
      @(posedge ref_clk) pre_t <= 1'b1;
      idle(3);
      chk(NB'(restart_n), 40'h0);
      @(posedge ref_clk) pre_t <= 1'b0;
      idle(3);
      chk(NB'(restart_n), 40'h1);
      $display("test restart pin done");
      report_and_stop();
   end
endmodule : tb_boundary_scan_test_port
